// *** include/spi_flash_seq_map.vh ***
`ifndef SPI_FLASH_SEQ_MAP_VH
`define SPI_FLASH_SEQ_MAP_VH
`define OP_WRSR 8'h01
`define OP_PROG 8'h02
`define OP_READ 8'h03
`define OP_WRDI 8'h04
`define OP_RDSR 8'h05
`define OP_WREN 8'h06
`define OP_FREAD 8'h0B
`define OP_EWSR 8'h50
`define OP_BAD_LO 8'h00
`define OP_BAD_HI 8'hFF
`define HW_WRSR 3'h0
`define HW_PROG 3'h1
`define HW_READ 3'h2
`define HW_WRDI 3'h3
`define HW_RDSR 3'h4
`define HW_WREN 3'h5
`define HW_FREAD 3'h6
`define HW_ERASE 3'h7
`define CS1_ADDR_BIT 24
`define SCK_HALF 2'h1
`define CS_GAP 3'h3
`define BUF_DEPTH 64
`define DUMMY_BYTE 8'h00
`define IDLE_BYTE 8'hFF
`define TX_MSB_MASK 8'h80
`define STAT_BUSY_BIT 0
`endif

// *** design/spi_flash_cycle_sequencer.v ***
`include "spi_flash_seq_map.vh"

module spi_flash_cycle_sequencer (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire descriptor_valid_i,
  input wire hw_go_i,
  input wire [2:0] hw_cmd_i,
  input wire [7:0] erase_opcode_i,
  input wire sw_go_i,
  input wire atomic_i,
  input wire [7:0] opcode_i,
  input wire [7:0] prefix_opcode_i,
  input wire has_addr_i,
  input wire has_dummy_i,
  input wire is_write_i,
  input wire [6:0] data_count_i,
  input wire [24:0] addr_i,
  input wire ctrl_we_i,
  input wire addr_we_i,
  input wire data_we_i,
  input wire [5:0] data_idx_i,
  input wire [7:0] data_wbyte_i,
  input wire [5:0] rd_idx_i,
  input wire done_clr_i,
  input wire err_clr_i,
  input wire direct_read_busy_i,
  input wire spi_miso_i,
  output reg [7:0] rdata_o,
  output reg busy_o,
  output reg done_o,
  output reg cycle_error_flag_o,
  output reg bus_lock_o,
  output reg spi_sck_o,
  output reg spi_mosi_o,
  output reg [1:0] spi_cs_n_o
);

  localparam ST_IDLE = 3'h0;
  localparam ST_PEND = 3'h1;
  localparam ST_LOAD = 3'h2;
  localparam ST_SHIFT = 3'h3;
  localparam ST_GAP = 3'h4;
  localparam SEG_PRE = 2'h0;
  localparam SEG_MAIN = 2'h1;
  localparam SEG_POLL = 2'h2;

  reg [7:0] data_buf [0:`BUF_DEPTH-1];
  reg [2:0] state;
  reg [1:0] seg;
  reg [7:0] op;
  reg [7:0] pre;
  reg haddr;
  reg hdum;
  reg wr;
  reg atomic;
  reg [6:0] cnt;
  reg [23:0] addr;
  reg cs_sel;
  reg [7:0] txsh;
  reg [7:0] rxsh;
  reg [7:0] stat_byte;
  reg [2:0] bitn;
  reg [6:0] bidx;
  reg [1:0] div;
  reg [2:0] gap;
  reg miso_meta;
  reg miso_s;

  wire [6:0] hdr_len = 7'h1 + (haddr ? 7'h3 : 7'h0) + (hdum ? 7'h1 : 7'h0);
  // frame length from type and count
  wire [6:0] flen = (seg == SEG_PRE) ? 7'h1 : (seg == SEG_POLL) ? 7'h2 : hdr_len + cnt;
  wire tick = (div == `SCK_HALF);
  wire byte_end = (state == ST_SHIFT) && tick && spi_sck_o && (bitn == 3'h7);
  wire [7:0] rx_byte = {rxsh[6:0], miso_s};
  wire eng_we = byte_end && (seg == SEG_MAIN) && !wr && (bidx >= hdr_len);
  wire [6:0] eng_idx = bidx - hdr_len;
  wire [6:0] nidx = bidx + 7'h1;
  wire len_ok = (data_count_i == 7'h0) || (data_count_i == 7'h1) || (data_count_i == 7'h2) ||
                (data_count_i == 7'h4) || (data_count_i == 7'h8) || (data_count_i == 7'h10) ||
                (data_count_i == 7'h20) || (data_count_i == 7'h40);
  wire op_ok = (opcode_i != `OP_BAD_LO) && (opcode_i != `OP_BAD_HI);
  wire late_wr = busy_o && (ctrl_we_i || addr_we_i || data_we_i);
  wire hw_bad = hw_go_i && !descriptor_valid_i;
  wire sw_bad = sw_go_i && !hw_go_i && !(len_ok && op_ok);
  wire fin = (state == ST_GAP) && (gap == `CS_GAP) &&
             ((seg == SEG_MAIN && !atomic) ||
              (seg == SEG_POLL && !stat_byte[`STAT_BUSY_BIT]));

  function [7:0] hw_opcode;
    input [2:0] cmd;
    input [7:0] erase_op;
    input erase_sel;
    begin
      case (cmd)
        `HW_WRSR: hw_opcode = `OP_WRSR;
        `HW_PROG: hw_opcode = `OP_PROG;
        `HW_READ: hw_opcode = `OP_READ;
        `HW_WRDI: hw_opcode = `OP_WRDI;
        `HW_RDSR: hw_opcode = `OP_RDSR;
        `HW_WREN: hw_opcode = `OP_WREN;
        `HW_FREAD: hw_opcode = `OP_FREAD;
        // code 7: erase with address, else status write enable
        `HW_ERASE: hw_opcode = erase_sel ? erase_op : `OP_EWSR;
        default: hw_opcode = erase_op;
      endcase
    end
  endfunction

  function [7:0] frame_byte;
    input [6:0] i;
    begin
      if (seg == SEG_PRE) begin
        frame_byte = pre;
      end else if (seg == SEG_POLL) begin
        frame_byte = (i == 7'h0) ? `OP_RDSR : `IDLE_BYTE;
      end else if (i == 7'h0) begin
        frame_byte = op;
      end else if (haddr && i == 7'h1) begin
        frame_byte = addr[23:16];
      end else if (haddr && i == 7'h2) begin
        frame_byte = addr[15:8];
      end else if (haddr && i == 7'h3) begin
        frame_byte = addr[7:0];
      end else if (i < hdr_len) begin
        frame_byte = `DUMMY_BYTE;
      end else begin
        frame_byte = wr ? data_buf[i[5:0] - hdr_len[5:0]] : `IDLE_BYTE;
      end
    end
  endfunction

  always @(posedge sys_clk_i) begin
    if (eng_we) begin
      data_buf[eng_idx[5:0]] <= rx_byte;
    end else if (data_we_i && !busy_o) begin
      data_buf[data_idx_i] <= data_wbyte_i;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_meta <= 1'b0;
      miso_s <= 1'b0;
      rdata_o <= 8'h00;
      cycle_error_flag_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      miso_meta <= spi_miso_i;
      miso_s <= miso_meta;
      rdata_o <= data_buf[rd_idx_i];
      if (late_wr || hw_bad || sw_bad) begin
        cycle_error_flag_o <= 1'b1;
      end else if (err_clr_i) begin
        cycle_error_flag_o <= 1'b0;
      end
      if (fin) begin
        done_o <= 1'b1;
      end else if (done_clr_i || (state == ST_IDLE && (hw_go_i || sw_go_i))) begin
        done_o <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      seg <= SEG_MAIN;
      op <= 8'h00;
      pre <= 8'h00;
      haddr <= 1'b0;
      hdum <= 1'b0;
      wr <= 1'b0;
      atomic <= 1'b0;
      cnt <= 7'h0;
      addr <= 24'h000000;
      cs_sel <= 1'b0;
      txsh <= 8'h00;
      rxsh <= 8'h00;
      stat_byte <= 8'h00;
      bitn <= 3'h0;
      bidx <= 7'h0;
      div <= 2'h0;
      gap <= 3'h0;
      busy_o <= 1'b0;
      bus_lock_o <= 1'b0;
      spi_sck_o <= 1'b0;
      spi_mosi_o <= 1'b0;
      spi_cs_n_o <= 2'h3;
    end else begin
      div <= tick ? 2'h0 : div + 2'h1;
      case (state)
        ST_IDLE: begin
          haddr <= has_addr_i;
          hdum <= has_dummy_i;
          wr <= is_write_i;
          cnt <= data_count_i;
          addr <= addr_i[23:0];
          pre <= prefix_opcode_i;
          cs_sel <= addr_i[`CS1_ADDR_BIT];
          if (hw_go_i && descriptor_valid_i) begin
            op <= hw_opcode(hw_cmd_i, erase_opcode_i, has_addr_i);
            atomic <= 1'b0;
            busy_o <= 1'b1;
            state <= ST_PEND;
          end else if (sw_go_i && !hw_go_i && len_ok && op_ok) begin
            op <= opcode_i;
            atomic <= atomic_i;
            busy_o <= 1'b1;
            state <= ST_PEND;
          end
        end
        ST_PEND: begin
          if (!direct_read_busy_i) begin
            seg <= atomic ? SEG_PRE : SEG_MAIN;
            bus_lock_o <= atomic;
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          spi_cs_n_o <= cs_sel ? 2'h1 : 2'h2;
          txsh <= frame_byte(7'h0);
          spi_mosi_o <= |(frame_byte(7'h0) & `TX_MSB_MASK);
          bidx <= 7'h0;
          bitn <= 3'h0;
          spi_sck_o <= 1'b0;
          state <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (tick && !spi_sck_o) begin
            spi_sck_o <= 1'b1;
          end else if (tick) begin
            // sample just before the fall: synchroniser lags two clocks
            spi_sck_o <= 1'b0;
            rxsh <= rx_byte;
            if (bitn == 3'h7) begin
              stat_byte <= rx_byte;
              if (nidx == flen) begin
                spi_cs_n_o <= 2'h3;
                gap <= 3'h0;
                state <= ST_GAP;
              end else begin
                bidx <= nidx;
                bitn <= 3'h0;
                txsh <= frame_byte(nidx);
                spi_mosi_o <= |(frame_byte(nidx) & `TX_MSB_MASK);
              end
            end else begin
              bitn <= bitn + 3'h1;
              txsh <= {txsh[6:0], 1'b0};
              spi_mosi_o <= txsh[6];
            end
          end
        end
        ST_GAP: begin
          if (gap != `CS_GAP) begin
            gap <= gap + 3'h1;
          end else if (fin) begin
            busy_o <= 1'b0;
            bus_lock_o <= 1'b0;
            state <= ST_IDLE;
          end else begin
            seg <= (seg == SEG_PRE) ? SEG_MAIN : SEG_POLL;
            state <= ST_LOAD;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// *** bench/seq_mon_monitor.sv ***
module seq_mon (
  input logic sys_clk_i,
  input logic rst_n_i,
  input logic descriptor_valid_i,
  input logic hw_go_i,
  input logic ctrl_we_i,
  input logic direct_read_busy_i,
  input logic busy_o,
  input logic done_o,
  input logic cycle_error_flag_o,
  input logic bus_lock_o,
  input logic spi_sck_o,
  input logic [1:0] spi_cs_n_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_hw_go;
    !busy_o && hw_go_i && !descriptor_valid_i;
  endsequence
  sequence s_wait;
    spi_cs_n_o == 2'h3 && direct_read_busy_i;
  endsequence
  a_hw_no_desc: assert property (s_hw_go |=> !busy_o && cycle_error_flag_o)
    else $error("hw go ran");
  a_pend_hold: assert property (s_wait |=> spi_cs_n_o == 2'h3)
    else $error("select during read");
  a_busy_write: assert property (busy_o && ctrl_we_i |=> cycle_error_flag_o)
    else $error("no error flag");
  a_done_gap: assert property ($rose(done_o) |-> $past(spi_cs_n_o, 4) == 2'h3)
    else $error("done early");
  a_done_fin: assert property ($fell(busy_o) |-> done_o)
    else $error("no done");
  a_lock_busy: assert property (bus_lock_o |-> busy_o)
    else $error("lock idle");
  a_sck_idle: assert property (spi_cs_n_o == 2'h3 |-> !spi_sck_o)
    else $error("stray sck");
  a_cs_single: assert property (spi_cs_n_o != 2'h0)
    else $error("two selects");
endmodule
bind spi_flash_cycle_sequencer seq_mon i_seq_mon (.*);

// *** bench/flash_model.sv ***
module flash_model (
  input logic spi_sck_o,
  input logic spi_mosi_o,
  input logic [1:0] spi_cs_n_o,
  output logic spi_miso_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh, tx, op;
  logic [7:0] q[$];
  logic [1:0] sel;
  int nbit = 0, nb = 0, polls = 0, nfr = 0;
  initial spi_miso_i = 1'b0;
  always @(spi_cs_n_o) begin
    if (spi_cs_n_o == 2'h3) begin
      // released line shows inverse
      spi_miso_i = ~spi_miso_i;
      if (op == 8'h05 && polls > 0) polls--;
    end else begin
      sel = spi_cs_n_o;
      nfr++;
      nbit = 0;
      nb = 0;
    end
  end
  always @(posedge spi_sck_o) if (spi_cs_n_o != 2'h3) begin
    sh = {sh[6:0], spi_mosi_o};
    nbit++;
    if (nbit == 8) begin
      q.push_back(sh);
      if (nb == 0) op = sh;
      nb++;
      nbit = 0;
    end
  end
  always @(negedge spi_sck_o) if (spi_cs_n_o != 2'h3) begin
    if (nbit == 0) tx = (op == 8'h05) ? {7'h00, polls > 0} : 8'hA0 + nb[7:0];
    spi_miso_i = tx[7];
    tx = {tx[6:0], 1'b0};
  end
endmodule

// *** bench/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, descriptor_valid_i = 1'b0, hw_go_i = 1'b0;
  logic sw_go_i = 1'b0, atomic_i = 1'b0, has_addr_i = 1'b0, has_dummy_i = 1'b0;
  logic is_write_i = 1'b0, ctrl_we_i = 1'b0, addr_we_i = 1'b0, data_we_i = 1'b0;
  logic done_clr_i = 1'b0, err_clr_i = 1'b0, direct_read_busy_i = 1'b0;
  logic [2:0] hw_cmd_i = 3'h0;
  logic [7:0] erase_opcode_i = 8'hD8, opcode_i = 8'h00, prefix_opcode_i = 8'h06;
  logic [7:0] data_wbyte_i = 8'h00, rdata_o;
  logic [6:0] data_count_i = 7'h00;
  logic [24:0] addr_i = 25'h0000000;
  logic [5:0] data_idx_i = 6'h00, rd_idx_i = 6'h00;
  logic [1:0] spi_cs_n_o;
  logic spi_miso_i, busy_o, done_o, cycle_error_flag_o, bus_lock_o, spi_sck_o, spi_mosi_o;
  int err_total = 0, n_tests = 0, k;
  spi_flash_cycle_sequencer i_spi_flash_cycle_sequencer (.*);
  flash_model i_flash_model (.*);
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic cyc(int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic run(logic h, logic [7:0] op, logic [24:0] a, logic [6:0] n, logic w);
    opcode_i = op;
    addr_i = a;
    data_count_i = n;
    is_write_i = w;
    i_flash_model.q.delete();
    i_flash_model.nfr = 0;
    {hw_go_i, sw_go_i} = h ? 2'h2 : 2'h1;
    cyc();
    {hw_go_i, sw_go_i} = 2'h0;
    for (k = 0; k < 3000 && done_o !== 1'b1; k++) cyc();
    chk("done", done_o, 1'b1);
    done_clr_i = 1'b1;
    cyc();
    done_clr_i = 1'b0;
  endtask
  task automatic refuse(logic h, logic [7:0] op, logic [6:0] n);
    opcode_i = op;
    data_count_i = n;
    err_clr_i = 1'b1;
    cyc();
    err_clr_i = 1'b0;
    chk("err clr", cycle_error_flag_o, 1'b0);
    {hw_go_i, sw_go_i} = h ? 2'h2 : 2'h1;
    cyc();
    {hw_go_i, sw_go_i} = 2'h0;
    cyc(2);
    chk("refused", {busy_o, cycle_error_flag_o}, 2'h1);
  endtask
  task automatic t_id;
    has_addr_i = 1'b0;
    run(1'b0, 8'h9F, 25'h1000000, 7'h02, 1'b0);
    chk("id len", i_flash_model.q.size(), 3);
    chk("id cs", i_flash_model.sel, 2'h1);
    rd_idx_i = 6'h01;
    cyc(2);
    chk("id data", rdata_o, 8'hA2);
  endtask
  task automatic t_wr;
    for (k = 0; k < 4; k++) begin
      data_idx_i = k[5:0];
      data_wbyte_i = 8'h30 + k[7:0];
      data_we_i = 1'b1;
      cyc();
    end
    data_we_i = 1'b0;
    has_addr_i = 1'b1;
    fork
      run(1'b0, 8'h02, 25'h0000155, 7'h04, 1'b1);
      begin
        cyc(40);
        addr_i = 25'h10000AA;
        data_wbyte_i = 8'hEE;
        data_we_i = 1'b1;
        ctrl_we_i = 1'b1;
        cyc();
        ctrl_we_i = 1'b0;
        data_we_i = 1'b0;
      end
    join
    chk("wr len", i_flash_model.q.size(), 8);
    chk("wr cs", i_flash_model.sel, 2'h2);
    chk("wr addr", i_flash_model.q[3], 8'h55);
    chk("wr data", i_flash_model.q[7], 8'h33);
    chk("wr err", cycle_error_flag_o, 1'b1);
  endtask
  task automatic t_at;
    atomic_i = 1'b1;
    i_flash_model.polls = 2;
    fork
      run(1'b0, 8'h0B, 25'h0000000, 7'h01, 1'b0);
      begin
        cyc(20);
        chk("lock", bus_lock_o, 1'b1);
      end
    join
    chk("unlock", bus_lock_o, 1'b0);
    chk("prefix", i_flash_model.q[0], 8'h06);
    chk("main", i_flash_model.q[1], 8'h0B);
    chk("poll", i_flash_model.q[10], 8'h05);
    chk("frames", i_flash_model.nfr, 5);
    atomic_i = 1'b0;
    has_addr_i = 1'b0;
  endtask
  task automatic t_pend;
    direct_read_busy_i = 1'b1;
    fork
      run(1'b0, 8'h05, 25'h0000000, 7'h01, 1'b0);
      begin
        cyc(30);
        chk("pend", {busy_o, spi_cs_n_o}, 3'h7);
        direct_read_busy_i = 1'b0;
      end
    join
  endtask
  task automatic t_hw;
    logic [7:0] opx[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0B, 8'h50};
    descriptor_valid_i = 1'b1;
    for (int c = 0; c < 8; c++) begin
      hw_cmd_i = c[2:0];
      run(1'b1, 8'h00, 25'h0000000, 7'h00, 1'b0);
      chk("hw op", i_flash_model.q[0], opx[c]);
    end
    erase_opcode_i = 8'h20;
    has_addr_i = 1'b1;
    run(1'b1, 8'h00, 25'h0000000, 7'h00, 1'b0);
    chk("erase", i_flash_model.q[0], 8'h20);
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(50 * 40000);
    err_total++;
    tally_and_finish();
  end
  initial begin
    cyc(10);
    rst_n_i = 1'b1;
    cyc();
    t_id();
    t_wr();
    t_at();
    t_pend();
    refuse(1'b1, 8'h03, 7'h01);
    refuse(1'b0, 8'hFF, 7'h01);
    refuse(1'b0, 8'h00, 7'h01);
    refuse(1'b0, 8'h03, 7'h03);
    t_hw();
    tally_and_finish();
  end
endmodule
